// ---- cdos_apb_host.sv ----
// apb master model standing in for the system controller
`timescale 1ns/1ns
module cdos_apb_host (
  // clock
  input wire logic clk,
  // apb master side
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  // idle bus from time zero
  initial begin
    paddr = 8'h00;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    pwdata = 32'h0;
  end

  // strobed register reads and writes
  // request held until pready; on release address and write data show inverted values
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // pready is read at the rising edge, before the slave updates it
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : cdos_apb_host

// ---- cdos_pkg.sv ----
// shared constants and types for the clock divider and output select block
package cdos_pkg;

  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] DIV_OFF = 8'h04;
  localparam logic [7:0] DEEP_OFF = 8'h08;
  localparam logic [7:0] JUMP_OFF = 8'h0C;
  localparam logic [7:0] STAT_OFF = 8'h10;

  // field positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_HOLD_BIT = 2;
  localparam int CTRL_LVL_BIT = 3;
  localparam int CTRL_DRVN_BIT = 4;
  localparam int STAT_CHAIN_LSB = 16;

  // reset values
  localparam logic [4:0] CTRL_RST = 5'h10;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [4:0] DEEP_RST = 5'h05;
  localparam logic [15:0] JUMP_RST = 16'h0000;

  // divider geometry
  localparam int CHAIN_W = 10;
  localparam int PDIV_W = 8;
  localparam logic [7:0] PDIV_TC = 8'hFF;
  localparam logic [5:0] PRE64_LAST = 6'h3F;
  localparam int DEEP_W = 30;
  localparam logic [4:0] DEEP_MIN = 5'h05;
  localparam logic [4:0] DEEP_MAX = 5'h1E;
  localparam int JUMP_W = 16;

  // output source codes, in listed order 0..3
  typedef enum logic [1:0] {
    SRC_TOP,
    SRC_HALF,
    SRC_PROG,
    SRC_DEEP
  } cdos_src_e;

  // phase jump sequencer
  typedef enum logic {
    J_IDLE,
    J_WAIT
  } cdos_jump_e;

  // control word as software writes it
  typedef struct packed {
    logic drive_en_n;
    logic static_output_level;
    logic hold_sel;
    cdos_src_e src;
  } cdos_ctrl_s;

endpackage : cdos_pkg

// ---- cdos_top.sv ----
// clock divider chain, source multiplexer and glitch-free fan-out stage
//
// Summary of operation
// - a binary chain on the top clock gives ratios 2 to 1024
// - one source is the top clock halved by one toggle stage
// - a four-way selector routes exactly one source to the output
// - programmable divider ratio is four times (256 minus load value)
// - counter flags terminal count low at 255, reloads on its next advance, two top clocks later
// - terminal count goes through one inverting register into toggle
// - toggle stage flips when controls high, holds when low
// - programmable output covers ratios 4 to 1024 in steps of four
// - deep source is top clock over 64 then over 2^n, n 5..30
// - slowest rates come from deep divider clocked at top over 64
// - selecting the undivided source stops every divider stage
// - deep divider count can jump forward or back by whole cycles
// - hold select low passes selector output, high passes level bit
// - outputs drive only while the active-low drive enable is low
// - enable changes land on falling edges, so no runt pulses
// - an active-low done flag reports a finished phase jump
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module cdos_top (
  // clock (the top-octave clock) and async active-low reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // fan-out stage and jump status
  output logic clk_out,
  output logic out_active,
  output logic jump_done_n
);

  logic rst_meta_q;
  logic rst_n;
  cdos_pkg::cdos_ctrl_s ctrl_q;
  logic [7:0] divider_load_value;
  logic [4:0] deep_n_q;
  logic [cdos_pkg::JUMP_W-1:0] jump_q;
  cdos_pkg::cdos_jump_e jstate_q;
  logic jump_done_n_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic setup;
  logic wr;
  logic stop;
  logic div2_q;
  logic [cdos_pkg::CHAIN_W-1:0] chain_q;
  logic [cdos_pkg::PDIV_W-1:0] pcnt_q;
  logic terminal_count_n;
  logic pipe_q;
  logic jk_q;
  logic tick64;
  logic [cdos_pkg::DEEP_W-1:0] deep_cnt_q;
  logic [cdos_pkg::DEEP_W-1:0] jump_next;
  logic deep_out;
  logic mux_clock_input;
  logic selected;
  logic sel_q;
  logic en_q;
  logic en_d;
  logic clk_out_q;

  // clamp a written exponent into the supported range
  function automatic logic [4:0] clamp_n(input logic [4:0] n);
    if (n < cdos_pkg::DEEP_MIN) begin
      return cdos_pkg::DEEP_MIN;
    end
    if (n > cdos_pkg::DEEP_MAX) begin
      return cdos_pkg::DEEP_MAX;
    end
    return n;
  endfunction : clamp_n

  // true for any mapped register offset
  function automatic logic addr_ok(input logic [7:0] a);
    return a == cdos_pkg::CTRL_OFF || a == cdos_pkg::DIV_OFF ||
      a == cdos_pkg::DEEP_OFF || a == cdos_pkg::JUMP_OFF ||
      a == cdos_pkg::STAT_OFF;
  endfunction : addr_ok

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // apb phases: answer is fixed at one access cycle, never stretched
  assign setup = psel && !penable;
  assign wr = psel && penable && pready_q && pwrite;

  // apb handshake and read data, all loaded in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !addr_ok(paddr);
      if (setup && !pwrite) begin
        prdata_q <= 32'h0000_0000;
        case (paddr)
          cdos_pkg::CTRL_OFF: prdata_q[4:0] <= ctrl_q;
          cdos_pkg::DIV_OFF: prdata_q[7:0] <= divider_load_value;
          cdos_pkg::DEEP_OFF: prdata_q[4:0] <= deep_n_q;
          cdos_pkg::JUMP_OFF: prdata_q[15:0] <= jump_q;
          cdos_pkg::STAT_OFF: begin
            prdata_q[0] <= clk_out_q;
            prdata_q[1] <= en_q;
            prdata_q[2] <= jump_done_n_q;
            prdata_q[3] <= terminal_count_n;
            prdata_q[4] <= jstate_q == cdos_pkg::J_WAIT;
            prdata_q[cdos_pkg::STAT_CHAIN_LSB +: cdos_pkg::CHAIN_W] <=
              chain_q;
          end
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control registers take effect at the completing access edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= cdos_pkg::CTRL_RST;
      divider_load_value <= cdos_pkg::DIV_RST;
      deep_n_q <= cdos_pkg::DEEP_RST;
    end else if (wr) begin
      case (paddr)
        cdos_pkg::CTRL_OFF: ctrl_q <= pwdata[4:0];
        cdos_pkg::DIV_OFF: divider_load_value <= pwdata[7:0];
        cdos_pkg::DEEP_OFF: deep_n_q <= clamp_n(pwdata[4:0]);
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  assign stop = ctrl_q.src == cdos_pkg::SRC_TOP;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div2_q <= 1'b0;
    end else begin
      div2_q <= stop ? 1'b0 : !div2_q;
    end
  end

  // binary counter chain, every bit on the top clock
  // bit k runs at the top rate over 2^(k+1); held at zero when stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_q <= '0;
    end else begin
      chain_q <= stop ? '0 : chain_q + 1'b1;
    end
  end

  assign terminal_count_n = pcnt_q != cdos_pkg::PDIV_TC;

  // loadable counter, advanced every second top clock
  // the halving prescale and the toggle stage each give a factor two, hence four
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcnt_q <= '0;
    end else if (stop) begin
      pcnt_q <= divider_load_value;
    end else if (div2_q) begin
      // reload on the next advance after terminal count, two top clocks later
      pcnt_q <= terminal_count_n ? pcnt_q + 1'b1 : divider_load_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe_q <= 1'b0;
    end else if (stop) begin
      pipe_q <= 1'b0;
    end else if (div2_q) begin
      pipe_q <= !terminal_count_n;
    end
  end

  // jk toggle with j and k tied to the pipeline stage
  // output period is 4 x (256 - load), 4 up to 1024
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jk_q <= 1'b0;
    end else if (stop) begin
      jk_q <= 1'b0;
    end else if (div2_q && pipe_q) begin
      jk_q <= !jk_q;
    end
  end

  // deep divider clocked once per 64 top clocks
  assign tick64 = !stop && chain_q[5:0] == cdos_pkg::PRE64_LAST;
  // jump adds a signed cycle count to the next step
  assign jump_next = deep_cnt_q + 30'h0000_0001 +
    {{(cdos_pkg::DEEP_W - cdos_pkg::JUMP_W){jump_q[cdos_pkg::JUMP_W-1]}},
     jump_q};
  // tap 2^n of the divide-by-64 rate
  assign deep_out = deep_cnt_q[deep_n_q - 5'h01];

  // deep counter; a jump is applied on the next divided tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deep_cnt_q <= '0;
    end else if (stop) begin
      deep_cnt_q <= '0;
    end else if (tick64) begin
      deep_cnt_q <= jstate_q == cdos_pkg::J_WAIT ? jump_next
        : deep_cnt_q + 1'b1;
    end
  end

  // jump request sequencer; a pending jump waits while stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jstate_q <= cdos_pkg::J_IDLE;
      jump_q <= cdos_pkg::JUMP_RST;
    end else begin
      if (wr && paddr == cdos_pkg::JUMP_OFF) begin
        jump_q <= pwdata[cdos_pkg::JUMP_W-1:0];
      end
      case (jstate_q)
        cdos_pkg::J_IDLE: begin
          if (wr && paddr == cdos_pkg::JUMP_OFF) begin
            jstate_q <= cdos_pkg::J_WAIT;
          end
        end
        cdos_pkg::J_WAIT: begin
          // a write landing on the apply tick starts a fresh jump
          if (tick64 && !(wr && paddr == cdos_pkg::JUMP_OFF)) begin
            jstate_q <= cdos_pkg::J_IDLE;
          end
        end
        default: jstate_q <= cdos_pkg::J_IDLE;
      endcase
    end
  end

  // done flag; completion wins over a same-cycle new request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jump_done_n_q <= 1'b1;
    end else if (tick64 && jstate_q == cdos_pkg::J_WAIT) begin
      jump_done_n_q <= 1'b0;
    end else if (wr && paddr == cdos_pkg::JUMP_OFF) begin
      jump_done_n_q <= 1'b1;
    end
  end

  // code order top, half, programmable, deep
  // the undivided clock cannot pass a flop; its code routes div2, which stop holds low
  always_comb begin
    case (ctrl_q.src)
      cdos_pkg::SRC_TOP: mux_clock_input = div2_q;
      cdos_pkg::SRC_HALF: mux_clock_input = div2_q;
      cdos_pkg::SRC_PROG: mux_clock_input = jk_q;
      cdos_pkg::SRC_DEEP: mux_clock_input = deep_out;
      default: mux_clock_input = 1'b0;
    endcase
  end

  // hold select picks the static level bit
  assign selected = ctrl_q.hold_sel ? ctrl_q.static_output_level
    : mux_clock_input;

  // enable follows request only on a falling edge
  // a parked level must therefore fall once before it shows
  assign en_d = (sel_q && !selected) ? !ctrl_q.drive_en_n : en_q;

  // fan-out output stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
      en_q <= 1'b0;
      clk_out_q <= 1'b0;
    end else begin
      sel_q <= selected;
      en_q <= en_d;
      clk_out_q <= en_d && selected;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign clk_out = clk_out_q;
  assign out_active = en_q;
  assign jump_done_n = jump_done_n_q;

  sequence running_s;
    !stop ##1 !stop;
  endsequence

  half_stage_a: assert property (
    running_s |-> div2_q != $past(div2_q))
    else $error("halving stage did not toggle");
  chain_count_a: assert property (
    running_s |-> chain_q == $past(chain_q) + 10'h001)
    else $error("divider chain did not advance");
  stop_all_a: assert property (
    stop |=> chain_q == '0 && !div2_q && !jk_q && !pipe_q)
    else $error("dividers active with undivided source");
  tc_reload_a: assert property (
    (div2_q && !terminal_count_n && !stop) ##1 !stop |->
      pcnt_q == $past(divider_load_value))
    else $error("counter did not reload after terminal count");
  pipe_inv_a: assert property (
    (div2_q && !stop) ##1 !stop |-> pipe_q == $past(!terminal_count_n))
    else $error("pipeline stage not inverted terminal count");
  jk_hold_a: assert property (
    (!pipe_q && !stop) ##1 !stop |-> $stable(jk_q))
    else $error("toggle stage moved with controls low");
  mux_route_a: assert property (
    ctrl_q.src == cdos_pkg::SRC_PROG |-> mux_clock_input == jk_q)
    else $error("selector routed wrong source");
  deep_jump_a: assert property (
    (tick64 && jstate_q == cdos_pkg::J_WAIT && !stop) |=>
      deep_cnt_q == $past(jump_next) && !jump_done_n_q)
    else $error("phase jump not applied");
  // the next tick may already apply the jump, so only one edge is checked
  jump_done_a: assert property (
    (wr && paddr == cdos_pkg::JUMP_OFF && !tick64) |=>
      jump_done_n_q && jstate_q == cdos_pkg::J_WAIT)
    else $error("done flag not released on new jump");
  hold_level_a: assert property (
    ctrl_q.hold_sel |-> selected == ctrl_q.static_output_level)
    else $error("hold select ignored");
  drive_off_a: assert property (
    !out_active |-> !clk_out)
    else $error("output driven while disabled");
  edge_enable_a: assert property (
    $changed(en_q) |-> $past(sel_q) && !$past(selected))
    else $error("enable changed off a falling edge");

endmodule : cdos_top

// ---- cdos_top_tb.sv ----
// self-checking bench for the clock divider and output select block
`timescale 1ns/1ns
module cdos_top_tb;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic clk_out;
  logic out_active;
  logic jump_done_n;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int p;
  int k;
  int jmp;
  logic [31:0] rd;
  logic [31:0] r0;
  logic er;
  logic [7:0] dvs[3];

  // design under test
  cdos_top i_cdos_top (
    .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .clk_out(clk_out), .out_active(out_active),
    .jump_done_n(jump_done_n)
  );

  // controller model on the register bus
  cdos_apb_host i_cdos_apb_host (
    .clk(clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr)
  );

  // 250 MHz clock
  always #2 clk = ~clk;

  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      summarize();
    end
  end

  task summarize;
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    i_cdos_apb_host.xfer(a, 1'h1, d, rd, er);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    i_cdos_apb_host.xfer(a, 1'h0, 32'h0, rd, er);
    chk("prdata", e, rd);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask : rdc

  // control word: drive enable low-active, level, hold, source
  function logic [31:0] ctl(input logic [1:0] s, input logic h,
                            input logic l, input logic n);
    return {27'h0, n, l, h, s};
  endfunction : ctl

  // cycles between rises 2 and 3, so stale settings are skipped
  task per(output int n);
    int r;
    logic v;
    r = 0;
    n = 0;
    v = clk_out;
    while (r < 3) begin
      @(negedge clk);
      if (r == 2) n++;
      if (clk_out === 1'h1 && v === 1'h0) r++;
      v = clk_out;
    end
  endtask : per

  task waitn(input int n);
    repeat (n) @(negedge clk);
  endtask : waitn

  // main sequence
  initial begin
    void'($urandom(13));
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    repeat (4) @(posedge clk);
    rdc(cdos_pkg::CTRL_OFF, {27'h0, cdos_pkg::CTRL_RST}, 1'h0);
    rdc(cdos_pkg::DIV_OFF, 32'h0, 1'h0);
    rdc(cdos_pkg::DEEP_OFF, {27'h0, cdos_pkg::DEEP_RST}, 1'h0);
    rdc(cdos_pkg::JUMP_OFF, 32'h0, 1'h0);
    wr(8'h14, 32'hFFFFFFFF);
    rdc(8'h14, 32'h0, 1'h1);
    dvs = '{8'hFF, 8'($urandom), 8'h00};
    foreach (dvs[i]) begin
      wr(cdos_pkg::DIV_OFF, {24'h0, dvs[i]});
      wr(cdos_pkg::CTRL_OFF, ctl(2'h2, 1'h0, 1'h0, 1'h0));
      per(p);
      chk("prog period", 4 * (256 - dvs[i]), p);
    end
    chk("active", 32'h1, {31'h0, out_active});
    wr(cdos_pkg::CTRL_OFF, ctl(2'h1, 1'h0, 1'h0, 1'h0));
    per(p);
    chk("half period", 32'h2, p);
    i_cdos_apb_host.xfer(cdos_pkg::STAT_OFF, 1'h0, 32'h0, r0, er);
    waitn(20);
    i_cdos_apb_host.xfer(cdos_pkg::STAT_OFF, 1'h0, 32'h0, rd, er);
    chk("pslverr", 32'h0, {31'h0, er});
    // no jump pending, done high, drive enabled
    chk("stat flags", 32'h3, {29'h0, rd[4], rd[2], rd[1]});
    chk("chain run", 32'h1, {31'h0, r0[25:16] != rd[25:16]});
    wr(cdos_pkg::CTRL_OFF, ctl(2'h0, 1'h0, 1'h0, 1'h0));
    waitn(8);
    i_cdos_apb_host.xfer(cdos_pkg::STAT_OFF, 1'h0, 32'h0, r0, er);
    waitn(20);
    i_cdos_apb_host.xfer(cdos_pkg::STAT_OFF, 1'h0, 32'h0, rd, er);
    chk("chain stop", 32'h0, {22'h0, r0[25:16] | rd[25:16]});
    // disable, then a parked high level must not enable
    wr(cdos_pkg::CTRL_OFF, ctl(2'h1, 1'h0, 1'h0, 1'h1));
    waitn(8);
    chk("disabled", 32'h0, {31'h0, out_active});
    wr(cdos_pkg::CTRL_OFF, ctl(2'h1, 1'h1, 1'h1, 1'h1));
    // controller parks then toggles the level
    wr(cdos_pkg::CTRL_OFF, ctl(2'h1, 1'h1, 1'h1, 1'h0));
    waitn(20);
    chk("no fall", 32'h0, {31'h0, out_active});
    wr(cdos_pkg::CTRL_OFF, ctl(2'h1, 1'h1, 1'h0, 1'h0));
    waitn(4);
    chk("fall en", 32'h1, {31'h0, out_active});
    chk("level lo", 32'h0, {31'h0, clk_out});
    wr(cdos_pkg::CTRL_OFF, ctl(2'h1, 1'h1, 1'h1, 1'h0));
    waitn(4);
    chk("level hi", 32'h1, {31'h0, clk_out});
    // deep divider range limits and rate
    wr(cdos_pkg::DEEP_OFF, 32'h0);
    rdc(cdos_pkg::DEEP_OFF, 32'h5, 1'h0);
    wr(cdos_pkg::DEEP_OFF, 32'h1F);
    rdc(cdos_pkg::DEEP_OFF, 32'h1E, 1'h0);
    wr(cdos_pkg::DEEP_OFF, 32'h5);
    wr(cdos_pkg::CTRL_OFF, ctl(2'h3, 1'h0, 1'h0, 1'h0));
    per(p);
    chk("deep period", 32'd2048, p);
    // each jump stays inside one output period
    // only the slow deep source jumps; the faster sources have no phase jump
    for (int s = 0; s < 2; s++) begin
      jmp = $urandom_range(31);
      wr(cdos_pkg::JUMP_OFF, {16'h0, 16'(s == 0 ? jmp : -jmp)});
      waitn(1);
      chk("done clr", 32'h1, {31'h0, jump_done_n});
      k = 0;
      while (jump_done_n !== 1'h0 && k < 70) begin
        waitn(1);
        k++;
      end
      chk("done set", 32'h0, {31'h0, jump_done_n});
    end
    summarize();
  end
endmodule : cdos_top_tb
